// ### rtl/amrr_consts.svh
// How it works
// - Right input stage enable, bit 15, resets off.
// - Bit 14 mutes the right input stage; reset is unmuted.
// - Bit 13 clear applies gain at once; set waits for zero cross.
// - Written gains stay pending until bit 8 written one in either input register.
// - Right gain code bits 7:2, six bits, reset code 010000.
// - Left output mixer enable bit 15, resets off.
// - Left output mixer source bits 12, 11, 2, 1, 0; only bit 11 resets set.
// - Right output mixer enable bit 15, resets off.
// - Right output mixer source bits 12, 11, 3, 1, 0; only bit 12 resets set.
// - Line output A enable bit 15, sources bits 11, 8, 3, 0, all reset clear.
// - Line output B enable bit 15, sources bits 12, 11, 9, 1, 0.
// - Line output B bit 10 lowers that output by 6dB.
// - Left output mixer gain fields 11:9, 7:5, 3:1, reset 000.
// - Path gain code 000 disconnects; 001 is -12dB up to 111 at +6dB.
// - Left input gain register at 50h mirrors right; its apply bit updates both.
`ifndef AMRR_CONSTS_SVH
`define AMRR_CONSTS_SVH

`define AMRR_NUM_REGS 7
`define AMRR_IDX_W 7
`define AMRR_DATA_W 16

// Register indices; byte address is four times the index
`define AMRR_IDX_LEFT_IN 7'h50
`define AMRR_IDX_RIGHT_IN 7'h51
`define AMRR_IDX_LEFT_OMIX 7'h58
`define AMRR_IDX_RIGHT_OMIX 7'h59
`define AMRR_IDX_LINE_A 7'h5c
`define AMRR_IDX_LINE_B 7'h5d
`define AMRR_IDX_LEFT_OGAIN 7'h60

// Storage slots
`define AMRR_SLOT_LEFT_IN 0
`define AMRR_SLOT_RIGHT_IN 1
`define AMRR_SLOT_LEFT_OMIX 2
`define AMRR_SLOT_RIGHT_OMIX 3
`define AMRR_SLOT_LINE_A 4
`define AMRR_SLOT_LINE_B 5
`define AMRR_SLOT_LEFT_OGAIN 6

// Writable bit masks
`define AMRR_MASK_IN 16'he0fc
`define AMRR_MASK_LEFT_OMIX 16'h9807
`define AMRR_MASK_RIGHT_OMIX 16'h980b
`define AMRR_MASK_LINE_A 16'h8909
`define AMRR_MASK_LINE_B 16'h9e03
`define AMRR_MASK_OGAIN 16'h0eee

// Reset values
`define AMRR_RST_IN 16'h0040
`define AMRR_RST_LEFT_OMIX 16'h0800
`define AMRR_RST_RIGHT_OMIX 16'h1000
`define AMRR_RST_ZERO 16'h0000
`define AMRR_RST_GAIN_CODE 6'h10

// Field positions
`define AMRR_B_ON 15
`define AMRR_B_SILENCE 14
`define AMRR_B_ZC 13
`define AMRR_B_APPLY 8
`define AMRR_F_GAIN_HI 7
`define AMRR_F_GAIN_LO 2
`define AMRR_B_RCONV 12
`define AMRR_B_LCONV 11
`define AMRR_B_HALVE 10
`define AMRR_B_RINMIX 9
`define AMRR_B_LINMIX 8
`define AMRR_B_RAUX 3
`define AMRR_B_LINE_B_TO_A 3
`define AMRR_B_LAUX 2
`define AMRR_B_RSTAGE 1
`define AMRR_B_LSTAGE 0
`define AMRR_F_AUXG_HI 11
`define AMRR_F_AUXG_LO 9
`define AMRR_F_RSG_HI 7
`define AMRR_F_RSG_LO 5
`define AMRR_F_LSG_HI 3
`define AMRR_F_LSG_LO 1

`endif

// ### rtl/amrr_pkg.sv
package amrr_pkg;
	typedef enum logic {
		AMRR_ZC_IDLE = 1'b0,
		AMRR_ZC_WAIT = 1'b1
	} amrr_zc_state_type;

	typedef logic [5:0] amrr_gain_code_type;
	typedef logic [2:0] amrr_path_gain_type;
endpackage : amrr_pkg

// ### rtl/amrr_reg_if.sv
`timescale 1ns/100ps
`include "amrr_consts.svh"
interface amrr_reg_if;
	logic wr_stb;
	logic [`AMRR_IDX_W-1:0] index;
	logic [`AMRR_DATA_W-1:0] wdata;
	logic [`AMRR_DATA_W-1:0] rdata;
	logic hit;

	modport port (output wr_stb, output index, output wdata,
		input rdata, input hit);
	modport regs (input wr_stb, input index, input wdata,
		output rdata, output hit);
endinterface : amrr_reg_if

// ### rtl/amrr_apb_port.sv
`timescale 1ns/100ps
`include "amrr_consts.svh"
module amrr_apb_port #(
	parameter int ADDR_W = 12
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	amrr_reg_if.port rif
);
	logic addr_ok;
	logic err_reg;
	logic ready_reg;
	logic [31:0] rdata_reg;

	// Word aligned, inside the index range
	assign addr_ok = (paddr[1:0] == 2'h0)
		&& (paddr[ADDR_W-1:2] < (ADDR_W-2)'(1 << `AMRR_IDX_W)) && rif.hit;
	assign rif.index = paddr[`AMRR_IDX_W+1:2];
	assign rif.wdata = pwdata[`AMRR_DATA_W-1:0];
	// Answer only after a capture made with the clock enabled
	assign pready = core_ce && psel && penable && ready_reg;
	assign rif.wr_stb = pready && pwrite && addr_ok;
	assign prdata = rdata_reg;
	assign pslverr = pready && err_reg;

	// Read data and error captured in the first enabled cycle of a transfer
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (core_ce && psel && !ready_reg) begin
			rdata_reg <= (!pwrite && addr_ok) ? {16'h0000, rif.rdata} : 32'h0000_0000;
			err_reg <= !addr_ok;
		end
	end

	// Setup with the clock disabled gets one wait state instead of stale data
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ready_reg <= 1'b0;
		end else if (core_ce && psel && !ready_reg) begin
			ready_reg <= 1'b1;
		end else if (core_ce && (pready || !psel)) begin
			ready_reg <= 1'b0;
		end
	end
endmodule : amrr_apb_port

// ### rtl/amrr_gain_stage.sv
`timescale 1ns/100ps
`include "amrr_consts.svh"
module amrr_gain_stage (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	input wire logic apply,
	input wire logic zc_mode,
	input wire amrr_pkg::amrr_gain_code_type pending_code,
	input wire logic zero_cross,
	output amrr_pkg::amrr_gain_code_type active_code,
	output logic waiting
);
	amrr_pkg::amrr_zc_state_type state_reg;
	amrr_pkg::amrr_gain_code_type target_reg;
	amrr_pkg::amrr_gain_code_type active_reg;

	assign active_code = active_reg;
	assign waiting = (state_reg == amrr_pkg::AMRR_ZC_WAIT);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			target_reg <= `AMRR_RST_GAIN_CODE;
		end else if (core_ce && apply) begin
			target_reg <= pending_code;
		end
	end

	// A new apply in the crossing cycle wins; it restarts the wait only with zero cross mode set
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= amrr_pkg::AMRR_ZC_IDLE;
		end else if (core_ce) begin
			case (state_reg)
				amrr_pkg::AMRR_ZC_IDLE: begin
					if (apply && zc_mode) begin
						state_reg <= amrr_pkg::AMRR_ZC_WAIT;
					end
				end
				amrr_pkg::AMRR_ZC_WAIT: begin
					if (apply) begin
						state_reg <= zc_mode ? amrr_pkg::AMRR_ZC_WAIT : amrr_pkg::AMRR_ZC_IDLE;
					end else if (zero_cross) begin
						state_reg <= amrr_pkg::AMRR_ZC_IDLE;
					end
				end
				default: begin
					state_reg <= amrr_pkg::AMRR_ZC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_reg <= `AMRR_RST_GAIN_CODE;
		end else if (core_ce) begin
			if (apply && !zc_mode) begin
				active_reg <= pending_code;
			end else if (!apply && waiting && zero_cross) begin
				active_reg <= target_reg;
			end
		end
	end
endmodule : amrr_gain_stage

// ### rtl/amrr_regs.sv
`timescale 1ns/100ps
`include "amrr_consts.svh"
module amrr_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Zero crossing pulses, left then right
	input wire logic left_in_zero_cross,
	input wire logic right_in_zero_cross,
	// Input gain stages
	output logic left_in_stage_on,
	output logic left_in_stage_silence,
	output logic [5:0] left_in_gain_code,
	output logic left_in_gain_waiting,
	output logic right_in_stage_on,
	output logic right_in_stage_silence,
	output logic [5:0] right_in_gain_code,
	output logic right_in_gain_waiting,
	// Left output mixer
	output logic left_outmix_on,
	output logic rconv_to_left_outmix,
	output logic lconv_to_left_outmix,
	output logic left_aux_to_left_outmix,
	output logic rstage_to_left_outmix,
	output logic lstage_to_left_outmix,
	// Right output mixer
	output logic right_outmix_on,
	output logic rconv_to_right_outmix,
	output logic lconv_to_right_outmix,
	output logic right_aux_to_right_outmix,
	output logic rstage_to_right_outmix,
	output logic lstage_to_right_outmix,
	// Line output A
	output logic line_a_on,
	output logic lconv_to_line_a,
	output logic left_inmix_to_line_a,
	output logic line_b_to_line_a,
	output logic left_outmix_to_line_a,
	// Line output B
	output logic line_b_on,
	output logic rconv_to_line_b,
	output logic lconv_to_line_b,
	output logic line_b_halve,
	output logic right_inmix_to_line_b,
	output logic right_outmix_to_line_b,
	output logic left_outmix_to_line_b,
	// Left output mixer path gains
	output logic [2:0] left_aux_path_gain,
	output logic [2:0] rstage_path_gain,
	output logic [2:0] lstage_path_gain
);
	localparam int NREG = `AMRR_NUM_REGS;

	// ---------------------------------------------------------------
	// Register map tables
	// ---------------------------------------------------------------
	localparam logic [`AMRR_IDX_W-1:0] REG_IDX [NREG] = '{
		`AMRR_IDX_LEFT_IN, `AMRR_IDX_RIGHT_IN, `AMRR_IDX_LEFT_OMIX,
		`AMRR_IDX_RIGHT_OMIX, `AMRR_IDX_LINE_A, `AMRR_IDX_LINE_B,
		`AMRR_IDX_LEFT_OGAIN};
	localparam logic [`AMRR_DATA_W-1:0] REG_MASK [NREG] = '{
		`AMRR_MASK_IN, `AMRR_MASK_IN, `AMRR_MASK_LEFT_OMIX,
		`AMRR_MASK_RIGHT_OMIX, `AMRR_MASK_LINE_A, `AMRR_MASK_LINE_B,
		`AMRR_MASK_OGAIN};
	localparam logic [`AMRR_DATA_W-1:0] REG_RST [NREG] = '{
		`AMRR_RST_IN, `AMRR_RST_IN, `AMRR_RST_LEFT_OMIX,
		`AMRR_RST_RIGHT_OMIX, `AMRR_RST_ZERO, `AMRR_RST_ZERO,
		`AMRR_RST_ZERO};

	amrr_reg_if rif ();

	logic [`AMRR_DATA_W-1:0] store_reg [NREG];
	logic [NREG-1:0] sel;
	logic [`AMRR_DATA_W-1:0] rd_mux;
	logic [1:0] apply_bit;
	logic apply_any;
	logic [1:0] zero_cross;
	logic [1:0] zc_mode;
	amrr_pkg::amrr_gain_code_type pending_code [2];
	amrr_pkg::amrr_gain_code_type active_code [2];
	logic [1:0] waiting;

	// ---------------------------------------------------------------
	// Bus port
	// ---------------------------------------------------------------
	amrr_apb_port #(
		.ADDR_W(ADDR_W)
	) u_port (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.core_ce(core_ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.rif(rif.port)
	);

	// ---------------------------------------------------------------
	// Storage, one word per register
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		assign sel[i] = (rif.index == REG_IDX[i]);

		// Undefined and unsupported bits are masked off
		always_ff @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				store_reg[i] <= REG_RST[i];
			end else if (core_ce && rif.wr_stb && sel[i]) begin
				store_reg[i] <= rif.wdata & REG_MASK[i];
			end
		end
	end

	assign rif.hit = |sel;

	always_comb begin
		rd_mux = 16'h0000;
		for (int i = 0; i < NREG; i++) begin
			if (sel[i]) begin
				rd_mux = store_reg[i];
			end
		end
	end
	assign rif.rdata = rd_mux;

	// ---------------------------------------------------------------
	// Input gain stages, left slot 0 and right slot 1
	// ---------------------------------------------------------------
	// The apply bit is not stored; it reads back as zero
	assign apply_bit[0] = sel[`AMRR_SLOT_LEFT_IN] && rif.wdata[`AMRR_B_APPLY];
	assign apply_bit[1] = sel[`AMRR_SLOT_RIGHT_IN] && rif.wdata[`AMRR_B_APPLY];
	assign apply_any = rif.wr_stb && (|apply_bit);
	assign zero_cross = {right_in_zero_cross, left_in_zero_cross};

	for (genvar c = 0; c < 2; c++) begin : g_stage
		// Gain and mode from the same write take effect with it
		assign pending_code[c] = (rif.wr_stb && apply_bit[c])
			? rif.wdata[`AMRR_F_GAIN_HI:`AMRR_F_GAIN_LO]
			: store_reg[c][`AMRR_F_GAIN_HI:`AMRR_F_GAIN_LO];
		assign zc_mode[c] = (rif.wr_stb && apply_bit[c])
			? rif.wdata[`AMRR_B_ZC] : store_reg[c][`AMRR_B_ZC];

		amrr_gain_stage u_stage (
			.core_clk(core_clk),
			.reset_n(reset_n),
			.core_ce(core_ce),
			.apply(apply_any),
			.zc_mode(zc_mode[c]),
			.pending_code(pending_code[c]),
			.zero_cross(zero_cross[c]),
			.active_code(active_code[c]),
			.waiting(waiting[c])
		);
	end

	assign left_in_stage_on = store_reg[`AMRR_SLOT_LEFT_IN][`AMRR_B_ON];
	assign left_in_stage_silence = store_reg[`AMRR_SLOT_LEFT_IN][`AMRR_B_SILENCE];
	assign left_in_gain_code = active_code[0];
	assign left_in_gain_waiting = waiting[0];
	assign right_in_stage_on = store_reg[`AMRR_SLOT_RIGHT_IN][`AMRR_B_ON];
	assign right_in_stage_silence = store_reg[`AMRR_SLOT_RIGHT_IN][`AMRR_B_SILENCE];
	assign right_in_gain_code = active_code[1];
	assign right_in_gain_waiting = waiting[1];

	// ---------------------------------------------------------------
	// Output mixers and line outputs
	// ---------------------------------------------------------------
	assign left_outmix_on = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_ON];
	assign rconv_to_left_outmix = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_RCONV];
	assign lconv_to_left_outmix = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_LCONV];
	assign left_aux_to_left_outmix = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_LAUX];
	assign rstage_to_left_outmix = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_RSTAGE];
	assign lstage_to_left_outmix = store_reg[`AMRR_SLOT_LEFT_OMIX][`AMRR_B_LSTAGE];

	assign right_outmix_on = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_ON];
	assign rconv_to_right_outmix = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_RCONV];
	assign lconv_to_right_outmix = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_LCONV];
	assign right_aux_to_right_outmix = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_RAUX];
	assign rstage_to_right_outmix = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_RSTAGE];
	assign lstage_to_right_outmix = store_reg[`AMRR_SLOT_RIGHT_OMIX][`AMRR_B_LSTAGE];

	assign line_a_on = store_reg[`AMRR_SLOT_LINE_A][`AMRR_B_ON];
	assign lconv_to_line_a = store_reg[`AMRR_SLOT_LINE_A][`AMRR_B_LCONV];
	assign left_inmix_to_line_a = store_reg[`AMRR_SLOT_LINE_A][`AMRR_B_LINMIX];
	assign line_b_to_line_a = store_reg[`AMRR_SLOT_LINE_A][`AMRR_B_LINE_B_TO_A];
	assign left_outmix_to_line_a = store_reg[`AMRR_SLOT_LINE_A][`AMRR_B_LSTAGE];

	assign line_b_on = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_ON];
	assign rconv_to_line_b = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_RCONV];
	assign lconv_to_line_b = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_LCONV];
	assign line_b_halve = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_HALVE];
	assign right_inmix_to_line_b = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_RINMIX];
	assign right_outmix_to_line_b = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_RSTAGE];
	assign left_outmix_to_line_b = store_reg[`AMRR_SLOT_LINE_B][`AMRR_B_LSTAGE];

	// Code 000 disconnects the path downstream
	assign left_aux_path_gain =
		store_reg[`AMRR_SLOT_LEFT_OGAIN][`AMRR_F_AUXG_HI:`AMRR_F_AUXG_LO];
	assign rstage_path_gain =
		store_reg[`AMRR_SLOT_LEFT_OGAIN][`AMRR_F_RSG_HI:`AMRR_F_RSG_LO];
	assign lstage_path_gain =
		store_reg[`AMRR_SLOT_LEFT_OGAIN][`AMRR_F_LSG_HI:`AMRR_F_LSG_LO];
endmodule : amrr_regs

// ### bench/amrr_regs_assertions.sv
`timescale 1ns/100ps
module amrr_regs_assertions #(
	parameter int ADDR_W = 12
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic right_in_zero_cross,
	input wire logic right_in_stage_on,
	input wire logic right_in_stage_silence,
	input wire logic [5:0] right_in_gain_code,
	input wire logic right_in_gain_waiting,
	input wire logic left_outmix_on,
	input wire logic lconv_to_left_outmix,
	input wire logic right_outmix_on,
	input wire logic rconv_to_right_outmix,
	input wire logic line_a_on,
	input wire logic [2:0] lstage_path_gain
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	logic wr;
	logic mapped;
	logic apply_wr;
	assign wr = psel & penable & pready & pwrite;
	assign mapped = paddr inside {12'h140, 12'h144, 12'h160, 12'h164, 12'h170, 12'h174, 12'h180};
	assign apply_wr = wr & (paddr == 12'h140 || paddr == 12'h144) & pwdata[8];
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_SLVERR: assert property (pready |-> pslverr == !mapped)
		else $error("error response wrong");
	AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	AST_RIN_BITS: assert property (wr && paddr == 12'h144 |=>
		{right_in_stage_on, right_in_stage_silence} == $past(pwdata[15:14]))
		else $error("right stage bits wrong");
	AST_ZC_NOW: assert property (wr && paddr == 12'h144 && pwdata[8] && !pwdata[13] |=>
		right_in_gain_code == $past(pwdata[7:2]) && !right_in_gain_waiting)
		else $error("immediate gain not applied");
	AST_ZC_WAIT: assert property ($rose(right_in_gain_waiting) |-> $past(apply_wr))
		else $error("wait without apply");
	AST_ZC_TAKE: assert property (right_in_gain_waiting && right_in_zero_cross && !apply_wr && core_ce
		|=> !right_in_gain_waiting)
		else $error("zero cross not taken");
	AST_GAIN_HOLD: assert property ($changed(right_in_gain_code) |->
		$past(apply_wr) || $past(right_in_zero_cross && right_in_gain_waiting))
		else $error("gain changed without apply");
	AST_LOMIX: assert property (wr && paddr == 12'h160 |=>
		{left_outmix_on, lconv_to_left_outmix} == {$past(pwdata[15]), $past(pwdata[11])})
		else $error("left mixer bits wrong");
	AST_ROMIX: assert property (wr && paddr == 12'h164 |=>
		{right_outmix_on, rconv_to_right_outmix} == {$past(pwdata[15]), $past(pwdata[12])})
		else $error("right mixer bits wrong");
	AST_LINE_A: assert property (wr && paddr == 12'h170 |=> line_a_on == $past(pwdata[15]))
		else $error("line a enable wrong");
	AST_OGAIN: assert property (wr && paddr == 12'h180 |=>
		lstage_path_gain == $past(pwdata[3:1]))
		else $error("path gain wrong");
	cover property (apply_wr);
	cover property (right_in_gain_waiting && right_in_zero_cross);
	cover property (pready && pslverr);
endmodule : amrr_regs_assertions

// ### bench/amrr_regs_tb.sv
`timescale 1ns/100ps
`include "amrr_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("unexpected %0t: got %h exp %h", $time, a, e); end end
module amrr_regs_tb;
	localparam logic [6:0] IDX [7] = '{`AMRR_IDX_LEFT_IN, `AMRR_IDX_RIGHT_IN, `AMRR_IDX_LEFT_OMIX,
		`AMRR_IDX_RIGHT_OMIX, `AMRR_IDX_LINE_A, `AMRR_IDX_LINE_B, `AMRR_IDX_LEFT_OGAIN};
	localparam logic [15:0] MASK [7] = '{`AMRR_MASK_IN, `AMRR_MASK_IN, `AMRR_MASK_LEFT_OMIX,
		`AMRR_MASK_RIGHT_OMIX, `AMRR_MASK_LINE_A, `AMRR_MASK_LINE_B, `AMRR_MASK_OGAIN};
	localparam logic [15:0] RST [7] = '{`AMRR_RST_IN, `AMRR_RST_IN, `AMRR_RST_LEFT_OMIX,
		`AMRR_RST_RIGHT_OMIX, `AMRR_RST_ZERO, `AMRR_RST_ZERO, `AMRR_RST_ZERO};
	logic core_clk, reset_n, core_ce, psel, penable, pwrite, pready, pslverr;
	logic left_in_zero_cross, right_in_zero_cross;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic left_in_stage_on, left_in_stage_silence, left_in_gain_waiting;
	logic right_in_stage_on, right_in_stage_silence, right_in_gain_waiting;
	logic [5:0] left_in_gain_code, right_in_gain_code;
	logic left_outmix_on, rconv_to_left_outmix, lconv_to_left_outmix, left_aux_to_left_outmix;
	logic rstage_to_left_outmix, lstage_to_left_outmix, right_outmix_on, rconv_to_right_outmix;
	logic lconv_to_right_outmix, right_aux_to_right_outmix, rstage_to_right_outmix;
	logic lstage_to_right_outmix, line_a_on, lconv_to_line_a, left_inmix_to_line_a;
	logic line_b_to_line_a, left_outmix_to_line_a, line_b_on, rconv_to_line_b, lconv_to_line_b;
	logic line_b_halve, right_inmix_to_line_b, right_outmix_to_line_b, left_outmix_to_line_b;
	logic [2:0] left_aux_path_gain, rstage_path_gain, lstage_path_gain;
	logic [15:0] m [7];
	logic [33:0] e;
	logic [33:0] exp_q [$];
	int seed, n_fail, compares, cycles;

	amrr_regs #(.ADDR_W(12)) amrr_regs_i (.*);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [11:0] addr(input int i);
		return {3'h0, IDX[i], 2'b00};
	endfunction : addr

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		int k;
		k = -1;
		for (int i = 0; i < 7; i++) if (a == addr(i)) k = i;
		if (w && k >= 0) m[k] = dat[15:0] & MASK[k];
		exp_q.push_back({w, k < 0, (k < 0) ? 32'h0 : {16'h0, m[k]}});
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic do_reset();
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 7; i++) m[i] = RST[i];
	endtask : do_reset

	task automatic read_all();
		for (int i = 0; i < 7; i++) apb(1'b0, addr(i), $random(seed));
	endtask : read_all

	task automatic stall_ce();
		fork
			begin
				@(posedge core_clk);
				core_ce <= 1'b0;
				repeat (3) @(posedge core_clk);
				core_ce <= 1'b1;
			end
		join_none
	endtask : stall_ce

	task automatic check_outs();
		@(negedge core_clk);
		`CHK({left_in_stage_on, left_in_stage_silence, right_in_stage_on, right_in_stage_silence}, {m[0][15:14], m[1][15:14]})
		`CHK({left_outmix_on, rconv_to_left_outmix, lconv_to_left_outmix, left_aux_to_left_outmix, rstage_to_left_outmix, lstage_to_left_outmix}, {m[2][15], m[2][12:11], m[2][2:0]})
		`CHK({right_outmix_on, rconv_to_right_outmix, lconv_to_right_outmix, right_aux_to_right_outmix, rstage_to_right_outmix, lstage_to_right_outmix}, {m[3][15], m[3][12:11], m[3][3], m[3][1:0]})
		`CHK({line_a_on, lconv_to_line_a, left_inmix_to_line_a, line_b_to_line_a, left_outmix_to_line_a}, {m[4][15], m[4][11], m[4][8], m[4][3], m[4][0]})
		`CHK({line_b_on, rconv_to_line_b, lconv_to_line_b, line_b_halve, right_inmix_to_line_b, right_outmix_to_line_b, left_outmix_to_line_b}, {m[5][15], m[5][12:9], m[5][1:0]})
		`CHK({left_aux_path_gain, rstage_path_gain, lstage_path_gain}, {m[6][11:9], m[6][7:5], m[6][3:1]})
	endtask : check_outs

	task automatic chk_gain(input amrr_pkg::amrr_gain_code_type l, input amrr_pkg::amrr_gain_code_type r, input logic rw);
		@(negedge core_clk);
		`CHK({left_in_gain_code, right_in_gain_code, left_in_gain_waiting, right_in_gain_waiting}, {l, r, 1'b0, rw})
	endtask : chk_gain

	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Stimulus and monitor
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		left_in_zero_cross <= $random(seed);
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			`CHK(pslverr, e[32])
			if (!e[33]) `CHK(prdata, e[31:0])
		end
	end

	// Ceiling well above the length of all tests
	initial begin
		wait (cycles == 3000);
		n_fail++;
		final_report();
	end

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, right_in_zero_cross} = '0;
		left_in_zero_cross = 1'b0;
		core_ce = 1'b1;
		seed = 99183;
		do_reset();
		check_outs();
		chk_gain(6'h10, 6'h10, 1'b0);
		read_all();
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			d = $random(seed);
			if (i < 2) d[8] = 1'b0;
			if (i == 5) d[2] = 1'b0;
			if (i == 3) stall_ce();
			apb(1'b1, addr(i), d);
		end
		check_outs();
		read_all();
		apb(1'b1, 12'h148, 32'hffff_ffff);
		apb(1'b0, 12'h148, 32'h0);
		apb(1'b0, 12'h142, 32'h0);
		stall_ce();
		apb(1'b0, addr(5), 32'h0);
		$display("test access done");
		apb(1'b1, addr(0), 32'h0000_00a8);
		chk_gain(6'h10, 6'h10, 1'b0);
		apb(1'b1, addr(1), 32'h0000_0114);
		chk_gain(6'h2a, 6'h05, 1'b0);
		apb(1'b1, addr(1), 32'h0000_20fc);
		apb(1'b1, addr(0), 32'h0000_0100);
		chk_gain(6'h00, 6'h05, 1'b1);
		@(posedge core_clk);
		right_in_zero_cross <= 1'b1;
		@(posedge core_clk);
		right_in_zero_cross <= 1'b0;
		chk_gain(6'h00, 6'h3f, 1'b0);
		$display("test gain done");
		do_reset();
		check_outs();
		chk_gain(6'h10, 6'h10, 1'b0);
		read_all();
		$display("test second reset done");
		final_report();
	end
endmodule : amrr_regs_tb

bind amrr_regs amrr_regs_assertions #(.ADDR_W(ADDR_W)) amrr_regs_assertions_i (.*);
